// ==== hdl/sbp_pkg.sv ====
// shared constants and types for the shift/button front end and its prog port
package sbp_pkg;
	localparam real CLK_PERIOD_NS = 40.0;

	localparam real PROG_SETUP_MIN_MS = 3.5;
	localparam real PROG_SETUP_MAX_MS = 4.5;
	localparam real PROG_SETUP_TGT_MS = 4.0;
	localparam real PROG_HOLD1_MS     = 3.5;
	localparam real BULK_ERASE_MS     = 4.0;
	localparam real PROG_DELAY_MS     = 4.0;
	localparam real WRITE_CYCLE_MS    = 50.0;
	localparam real CLK_PHASE_US      = 50.0;
	localparam real SHIFT_HOLD_S      = 8.0;

	localparam int PROG_SETUP_MIN_CYC =
		int'($ceil(PROG_SETUP_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int PROG_SETUP_MAX_CYC =
		int'($floor(PROG_SETUP_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int PROG_SETUP_TGT_CYC =
		int'($ceil(PROG_SETUP_TGT_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int PROG_HOLD1_CYC =
		int'($ceil(PROG_HOLD1_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int BULK_ERASE_CYC =
		int'($ceil(BULK_ERASE_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int PROG_DELAY_CYC =
		int'($ceil(PROG_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int WRITE_CYCLE_CYC =
		int'($ceil(WRITE_CYCLE_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CLK_PHASE_CYC =
		int'($ceil(CLK_PHASE_US * 1.0e3 / CLK_PERIOD_NS));
	localparam int SHIFT_HOLD_CYC =
		int'($floor(SHIFT_HOLD_S * 1.0e9 / CLK_PERIOD_NS));

	localparam int WORD_BITS  = 16;
	localparam int NVM_BITS   = 192;
	localparam int NVM_WORDS  = 12;
	localparam int FIFO_DEPTH = 4;

	localparam logic [1:0] SHIFT_LEVEL_RST = 2'h0;
	localparam logic [1:0] IDX_A  = 2'h0;
	localparam logic [1:0] IDX_B  = 2'h1;
	localparam logic [1:0] IDX_AB = 2'h2;
	localparam logic [1:0] IDX_C  = 2'h3;

	// positions in the synchronised input vector of the device end
	localparam int IN_DATA  = 0;
	localparam int IN_C     = 1;
	localparam int IN_B     = 2;
	localparam int IN_A     = 3;
	localparam int IN_SHIFT = 4;
	localparam int IN_COUNT = 5;

	typedef enum logic [2:0] {
		DEV_IDLE   = 3'h0,
		DEV_SETUP  = 3'h1,
		DEV_ERASE  = 3'h2,
		DEV_LOAD   = 3'h3,
		DEV_VERIFY = 3'h4
	} sbp_dev_state_type;

	typedef enum logic [2:0] {
		PRG_IDLE   = 3'h0,
		PRG_SETUP  = 3'h1,
		PRG_HOLD   = 3'h2,
		PRG_ERASE  = 3'h3,
		PRG_LOW    = 3'h4,
		PRG_HIGH   = 3'h5,
		PRG_WAIT   = 3'h6
	} sbp_prg_state_type;
endpackage

// ==== hdl/sbp_link_if.sv ====
// link between encoder front end and programmer: clock pin and data pin
`timescale 1ns/10ps
interface sbp_link_if;
	logic button_c;
	logic data_dev_out;
	logic data_dev_oe;
	logic data_prg_out;
	logic data_prg_oe;
	logic data_line;

	// the pin is pulled down when nobody drives it
	assign data_line = (data_dev_oe & data_dev_out) |
		(data_prg_oe & data_prg_out);

	modport device (
		input  button_c,
		input  data_line,
		output data_dev_out,
		output data_dev_oe
	);
	modport programmer (
		output button_c,
		input  data_line,
		output data_prg_out,
		output data_prg_oe
	);
endinterface

// ==== hdl/sbp_encoder_front.sv ====
// encoder front end: shift level, function code, serial program/verify port
`timescale 1ns/10ps
module sbp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
)(
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_reg;
	logic [PW-1:0]    rd_ptr_reg;
	logic [CW-1:0]    count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != CW'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr_reg];

	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 :
					wr_ptr_reg + PW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 :
					rd_ptr_reg + PW'(1);
			if (push && !pop)
				count_reg <= count_reg + CW'(1);
			else if (pop && !push)
				count_reg <= count_reg - CW'(1);
		end
	end
endmodule

module sbp_encoder_front #(
	parameter int unsigned SETUP_MIN_CYC  = sbp_pkg::PROG_SETUP_MIN_CYC,
	parameter int unsigned SETUP_MAX_CYC  = sbp_pkg::PROG_SETUP_MAX_CYC,
	parameter int unsigned ERASE_CYC      = sbp_pkg::BULK_ERASE_CYC,
	parameter int unsigned WRITE_CYC      = sbp_pkg::PROG_DELAY_CYC,
	parameter int unsigned SHIFT_HOLD_CYC = sbp_pkg::SHIFT_HOLD_CYC,
	parameter int          FIFO_DEPTH     = sbp_pkg::FIFO_DEPTH
)(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	sbp_link_if.device       link,
	input  wire logic        button_a_input,
	input  wire logic        button_b_input,
	input  wire logic        shift_button,
	input  wire logic        tx_done,
	input  wire logic [3:0]  nvm_rd_addr,
	output logic [15:0]      nvm_rd_data,
	output logic             tx_req,
	output logic [3:0]       func_code,
	output logic             sync_tx_req,
	output logic [1:0]       shift_level,
	output logic             prog_active,
	output logic             verify_active
);
	localparam int N = sbp_pkg::IN_COUNT;
	localparam int WB = sbp_pkg::WORD_BITS;

	sbp_pkg::sbp_dev_state_type state_reg;
	logic [N-1:0]  s1_reg;
	logic [N-1:0]  s2_reg;
	logic [N-1:0]  s3_reg;
	logic [N-1:0]  stab_reg;
	logic [N-1:0]  prev_reg;
	logic [WB-1:0] nvm [sbp_pkg::NVM_WORDS];
	logic [31:0]   cnt_reg;
	logic [31:0]   hold_cnt_reg;
	logic [31:0]   wr_cnt_reg;
	logic [WB-1:0] shift_word_reg;
	logic [3:0]    bit_cnt_reg;
	logic          word_pend_reg;
	logic [3:0]    words_done_reg;
	logic [7:0]    vbit_reg;
	logic          vout_reg;
	logic [2:0]    btn_prev_reg;
	logic [2:0]    btn;
	logic          legal;
	logic [1:0]    idx;
	logic          c_rise;
	logic          c_fall;
	logic          shift_rise;
	logic          erase_now;
	logic          tx_ok;
	logic          fifo_in_ready;
	logic [WB-1:0] fifo_out_data;
	logic          fifo_out_valid;
	logic          fifo_pop;
	logic          wr_busy;

	// a change only counts once the second and third stage agree
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			stab_reg <= '0;
			prev_reg <= '0;
		end else begin
			s1_reg   <= {shift_button, button_a_input, button_b_input,
				link.button_c, link.data_line};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			stab_reg <= (s2_reg & s3_reg) | (stab_reg & (s2_reg | s3_reg));
			prev_reg <= stab_reg;
		end
	end

	assign c_rise = stab_reg[sbp_pkg::IN_C] & ~prev_reg[sbp_pkg::IN_C];
	assign c_fall = ~stab_reg[sbp_pkg::IN_C] & prev_reg[sbp_pkg::IN_C];
	assign shift_rise = stab_reg[sbp_pkg::IN_SHIFT] &
		~prev_reg[sbp_pkg::IN_SHIFT];
	assign btn = {stab_reg[sbp_pkg::IN_C], stab_reg[sbp_pkg::IN_B],
		stab_reg[sbp_pkg::IN_A]};
	// C clocks the port while programming, so it must not transmit then
	assign tx_ok = (state_reg == sbp_pkg::DEV_IDLE) ||
		(state_reg == sbp_pkg::DEV_SETUP);

	always_comb begin
		legal = 1'b1;
		idx   = sbp_pkg::IDX_A;
		unique case (btn)
			3'h1: idx = sbp_pkg::IDX_A;
			3'h2: idx = sbp_pkg::IDX_B;
			3'h3: idx = sbp_pkg::IDX_AB;
			3'h4: idx = sbp_pkg::IDX_C;
			default: legal = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			shift_level <= sbp_pkg::SHIFT_LEVEL_RST;
		else if (tx_done)
			shift_level <= sbp_pkg::SHIFT_LEVEL_RST;
		else if (shift_rise)
			shift_level <= shift_level + 2'h1;
		else if (hold_cnt_reg == SHIFT_HOLD_CYC - 1)
			shift_level <= sbp_pkg::SHIFT_LEVEL_RST;
	end

	// runs only while shift is up, no button is down and a level is held
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			hold_cnt_reg <= '0;
		else if (stab_reg[sbp_pkg::IN_SHIFT] || btn != 3'h0 ||
			shift_level == sbp_pkg::SHIFT_LEVEL_RST)
			hold_cnt_reg <= '0;
		else
			hold_cnt_reg <= hold_cnt_reg + 32'h1;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			btn_prev_reg <= 3'h0;
			tx_req       <= 1'b0;
			func_code    <= 4'h0;
		end else begin
			btn_prev_reg <= btn;
			tx_req       <= tx_ok && legal && btn != btn_prev_reg;
			if (tx_ok && legal && btn != btn_prev_reg)
				func_code <= {shift_level, idx};
		end
	end

	assign erase_now = (state_reg == sbp_pkg::DEV_SETUP) &&
		stab_reg[sbp_pkg::IN_DATA] && stab_reg[sbp_pkg::IN_C] &&
		cnt_reg >= SETUP_MIN_CYC && cnt_reg <= SETUP_MAX_CYC;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= sbp_pkg::DEV_IDLE;
			cnt_reg     <= '0;
			sync_tx_req <= 1'b0;
		end else begin
			sync_tx_req <= 1'b0;
			cnt_reg     <= cnt_reg + 32'h1;
			unique case (state_reg)
				sbp_pkg::DEV_IDLE: begin
					cnt_reg <= '0;
					if (c_rise)
						state_reg <= sbp_pkg::DEV_SETUP;
				end
				sbp_pkg::DEV_SETUP: begin
					if (erase_now) begin
						state_reg <= sbp_pkg::DEV_ERASE;
						cnt_reg   <= '0;
					end else if (c_fall) begin
						sync_tx_req <= stab_reg[sbp_pkg::IN_A] |
							stab_reg[sbp_pkg::IN_B];
						state_reg <= sbp_pkg::DEV_IDLE;
					end
				end
				sbp_pkg::DEV_ERASE: begin
					// leave only once the entry pins are back low
					if (cnt_reg >= ERASE_CYC && !stab_reg[sbp_pkg::IN_C] &&
						!stab_reg[sbp_pkg::IN_DATA])
						state_reg <= sbp_pkg::DEV_LOAD;
				end
				sbp_pkg::DEV_LOAD: begin
					if (words_done_reg == 4'(sbp_pkg::NVM_WORDS) &&
						!wr_busy && !fifo_out_valid)
						state_reg <= sbp_pkg::DEV_VERIFY;
				end
				sbp_pkg::DEV_VERIFY: begin
					if (c_fall &&
						vbit_reg == 8'(sbp_pkg::NVM_BITS - 1))
						state_reg <= sbp_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// bits are taken on the rising clock edge, first bit is the word's msb
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_word_reg <= '0;
			bit_cnt_reg    <= 4'h0;
			word_pend_reg  <= 1'b0;
		end else if (state_reg != sbp_pkg::DEV_LOAD) begin
			bit_cnt_reg   <= 4'h0;
			word_pend_reg <= 1'b0;
		end else if (word_pend_reg) begin
			// a full fifo stalls the shifter; further clocks are lost
			if (fifo_in_ready)
				word_pend_reg <= 1'b0;
		end else if (c_rise) begin
			shift_word_reg <= {shift_word_reg[WB-2:0],
				stab_reg[sbp_pkg::IN_DATA]};
			bit_cnt_reg    <= bit_cnt_reg + 4'h1;
			if (bit_cnt_reg == 4'(WB - 1))
				word_pend_reg <= 1'b1;
		end
	end

	sbp_fifo #(
		.WIDTH (WB),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_data   (shift_word_reg),
		.in_valid  (word_pend_reg),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (!wr_busy)
	);

	assign wr_busy  = (wr_cnt_reg != '0);
	assign fifo_pop = fifo_out_valid && !wr_busy;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_cnt_reg     <= '0;
			words_done_reg <= 4'h0;
		end else if (erase_now) begin
			wr_cnt_reg     <= '0;
			words_done_reg <= 4'h0;
		end else if (fifo_pop) begin
			wr_cnt_reg     <= WRITE_CYC;
			words_done_reg <= words_done_reg + 4'h1;
		end else if (wr_busy) begin
			wr_cnt_reg <= wr_cnt_reg - 32'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (erase_now) begin
			for (int i = 0; i < sbp_pkg::NVM_WORDS; i++)
				nvm[i] <= '0;
		end else if (fifo_pop &&
			words_done_reg < 4'(sbp_pkg::NVM_WORDS)) begin
			nvm[words_done_reg] <= fifo_out_data;
		end
		nvm_rd_data <= nvm[nvm_rd_addr];
	end

	// the next bit goes out on the clock's falling edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			vbit_reg <= 8'h0;
			vout_reg <= 1'b0;
		end else if (state_reg != sbp_pkg::DEV_VERIFY) begin
			vbit_reg <= 8'h0;
			vout_reg <= nvm[0][WB-1];
		end else if (c_fall) begin
			vbit_reg <= vbit_reg + 8'h1;
			vout_reg <= nvm[4'(vbit_reg[7:4] + {3'h0, &vbit_reg[3:0]})]
				[4'(~(vbit_reg[3:0] + 4'h1))];
		end
	end

	assign link.data_dev_out = vout_reg;
	assign link.data_dev_oe  = (state_reg == sbp_pkg::DEV_VERIFY);
	assign verify_active     = (state_reg == sbp_pkg::DEV_VERIFY);
	assign prog_active       = (state_reg == sbp_pkg::DEV_ERASE) ||
		(state_reg == sbp_pkg::DEV_LOAD);
endmodule

// ==== hdl/sbp_programmer.sv ====
// programmer end: enters program mode, loads 192 bits, verifies them once
`timescale 1ns/10ps
module sbp_programmer #(
	parameter int unsigned SETUP_CYC = sbp_pkg::PROG_SETUP_TGT_CYC,
	parameter int unsigned HOLD_CYC  = sbp_pkg::PROG_HOLD1_CYC,
	parameter int unsigned ERASE_CYC = sbp_pkg::BULK_ERASE_CYC,
	parameter int unsigned WRITE_CYC = sbp_pkg::WRITE_CYCLE_CYC,
	parameter int unsigned PHASE_CYC = sbp_pkg::CLK_PHASE_CYC
)(
	input  wire logic                       core_clk,
	input  wire logic                       rst_b,
	sbp_link_if.programmer                  link,
	input  wire logic                       start,
	input  wire logic [sbp_pkg::NVM_BITS-1:0] image,
	output logic                            busy,
	output logic                            done,
	output logic                            mismatch
);
	localparam int NB = sbp_pkg::NVM_BITS;

	sbp_pkg::sbp_prg_state_type state_reg;
	logic [31:0] cnt_reg;
	logic [7:0]  bit_reg;
	logic [7:0]  bit_next;
	logic        readback_reg;
	logic        s1_reg;
	logic        s2_reg;
	logic        s3_reg;
	logic        line_reg;
	logic        clk_out_reg;
	logic        dat_out_reg;
	logic        dat_oe_reg;
	logic        tx_bit;
	logic        nx_bit;
	logic        cnt_zero;

	assign bit_next = bit_reg + 8'h1;
	// words go msb first, so the low nibble of the bit count is mirrored
	assign tx_bit   = image[{bit_reg[7:4], ~bit_reg[3:0]}];
	assign nx_bit   = image[{bit_next[7:4], ~bit_next[3:0]}];
	assign cnt_zero = (cnt_reg == 32'h0);

	// the pin comes from the other end, so it is only believed once stable
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg   <= 1'b0;
			s2_reg   <= 1'b0;
			s3_reg   <= 1'b0;
			line_reg <= 1'b0;
		end else begin
			s1_reg <= link.data_line;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				line_reg <= s3_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg    <= sbp_pkg::PRG_IDLE;
			cnt_reg      <= 32'h0;
			bit_reg      <= 8'h0;
			readback_reg <= 1'b0;
			clk_out_reg  <= 1'b0;
			dat_out_reg  <= 1'b0;
			dat_oe_reg   <= 1'b0;
			busy         <= 1'b0;
			done         <= 1'b0;
			mismatch     <= 1'b0;
		end else begin
			if (!cnt_zero)
				cnt_reg <= cnt_reg - 32'h1;
			unique case (state_reg)
				sbp_pkg::PRG_IDLE: begin
					if (start) begin
						state_reg    <= sbp_pkg::PRG_SETUP;
						cnt_reg      <= SETUP_CYC - 1;
						bit_reg      <= 8'h0;
						readback_reg <= 1'b0;
						clk_out_reg  <= 1'b1;
						busy         <= 1'b1;
						done         <= 1'b0;
						mismatch     <= 1'b0;
					end
				end
				sbp_pkg::PRG_SETUP: begin
					if (cnt_zero) begin
						state_reg   <= sbp_pkg::PRG_HOLD;
						cnt_reg     <= HOLD_CYC - 1;
						dat_oe_reg  <= 1'b1;
						dat_out_reg <= 1'b1;
					end
				end
				sbp_pkg::PRG_HOLD: begin
					if (cnt_zero) begin
						state_reg   <= sbp_pkg::PRG_ERASE;
						cnt_reg     <= ERASE_CYC - 1;
						clk_out_reg <= 1'b0;
						dat_oe_reg  <= 1'b0;
						dat_out_reg <= 1'b0;
					end
				end
				sbp_pkg::PRG_ERASE: begin
					if (cnt_zero) begin
						state_reg   <= sbp_pkg::PRG_LOW;
						cnt_reg     <= PHASE_CYC - 1;
						dat_oe_reg  <= 1'b1;
						dat_out_reg <= tx_bit;
					end
				end
				sbp_pkg::PRG_LOW: begin
					if (cnt_zero) begin
						state_reg   <= sbp_pkg::PRG_HIGH;
						cnt_reg     <= PHASE_CYC - 1;
						clk_out_reg <= 1'b1;
					end
				end
				sbp_pkg::PRG_HIGH: begin
					if (cnt_zero) begin
						clk_out_reg <= 1'b0;
						bit_reg     <= bit_next;
						// sampled late in the high phase, past both synchronisers
						if (readback_reg && line_reg != tx_bit)
							mismatch <= 1'b1;
						if (readback_reg && bit_reg == 8'(NB - 1)) begin
							state_reg <= sbp_pkg::PRG_IDLE;
							busy      <= 1'b0;
							done      <= 1'b1;
						end else if (!readback_reg &&
							bit_reg[3:0] == 4'hF) begin
							state_reg   <= sbp_pkg::PRG_WAIT;
							cnt_reg     <= WRITE_CYC - 1;
							dat_oe_reg  <= 1'b0;
							dat_out_reg <= 1'b0;
						end else begin
							state_reg <= sbp_pkg::PRG_LOW;
							cnt_reg   <= PHASE_CYC - 1;
							if (!readback_reg)
								dat_out_reg <= nx_bit;
						end
					end
				end
				sbp_pkg::PRG_WAIT: begin
					if (cnt_zero) begin
						state_reg <= sbp_pkg::PRG_LOW;
						cnt_reg   <= PHASE_CYC - 1;
						if (bit_reg == 8'(NB)) begin
							// pin stays released: the device drives it now
							readback_reg <= 1'b1;
							bit_reg      <= 8'h0;
						end else begin
							dat_oe_reg  <= 1'b1;
							dat_out_reg <= tx_bit;
						end
					end
				end
			endcase
		end
	end

	assign link.button_c     = clk_out_reg;
	assign link.data_prg_out = dat_out_reg;
	assign link.data_prg_oe  = dat_oe_reg;
endmodule

// ==== tb/sbp_link_assertions.sv ====
// concurrent checks on the clock and data pins between programmer and device
`timescale 1ns/10ps
module sbp_link_assertions #(
	parameter int SET_MIN = 40,
	parameter int SET_MAX = 60,
	parameter int ERASE   = 30,
	parameter int WRITE   = 20
)(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic button_c,
	input wire logic data_dev_out,
	input wire logic data_dev_oe,
	input wire logic data_prg_out,
	input wire logic data_prg_oe,
	input wire logic data_line
);
	logic [15:0] high_reg;
	logic [15:0] gap_reg;
	logic [9:0]  bits_reg;
	logic        entered_reg;
	logic        c_d_reg;
	logic        drv_d_reg;
	logic        drv;
	logic        rise;
	logic        entry;
	assign drv = data_prg_oe & data_prg_out;
	assign rise = button_c & ~c_d_reg;
	// a long high phase tells the entry apart from data edges inside a word
	assign entry = drv & ~drv_d_reg & button_c & (high_reg > 16'h0010);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			c_d_reg <= 1'b0;
			drv_d_reg <= 1'b0;
			high_reg <= 16'h0000;
		end else begin
			c_d_reg <= button_c;
			drv_d_reg <= drv;
			high_reg <= !button_c ? 16'h0000 :
				(high_reg == 16'hFFFF ? high_reg : high_reg + 16'h0001);
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_reg <= 16'h0000;
			bits_reg <= 10'h000;
			entered_reg <= 1'b0;
		end else begin
			gap_reg <= (rise || entry) ? 16'h0000 :
				(gap_reg == 16'hFFFF ? gap_reg : gap_reg + 16'h0001);
			entered_reg <= entered_reg | entry;
			if (entry)
				bits_reg <= 10'h000;
			else if (rise && entered_reg && bits_reg != 10'h3FF)
				bits_reg <= bits_reg + 10'h001;
		end
	end
	chk_setup_window: assert property (@(posedge core_clk) disable iff (!rst_b)
		entry |-> high_reg >= SET_MIN && high_reg <= SET_MAX)
		else $error("program entry outside setup window");
	chk_erase_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
		rise && entered_reg && bits_reg == 10'h000 |-> gap_reg >= ERASE)
		else $error("data clocked before bulk erase ended");
	chk_word_pause: assert property (@(posedge core_clk) disable iff (!rst_b)
		rise && entered_reg && bits_reg != 10'h000 && bits_reg < 10'd192
		&& bits_reg[3:0] == 4'h0 |-> gap_reg >= WRITE)
		else $error("next word sent during write cycle");
	chk_verify_after_load: assert property (@(posedge core_clk) disable iff (!rst_b)
		data_dev_oe |-> entered_reg && bits_reg >= 10'd192)
		else $error("device drove data before a full load");
	chk_verify_once: assert property (@(posedge core_clk) disable iff (!rst_b)
		data_dev_oe |-> bits_reg <= 10'd385)
		else $error("device drove data after its single readout");
	chk_no_contention: assert property (@(posedge core_clk) disable iff (!rst_b)
		!(data_dev_oe && data_prg_oe))
		else $error("both ends drive the data pin");
	chk_line_pulldown: assert property (@(posedge core_clk) disable iff (!rst_b)
		!data_dev_oe && !data_prg_oe |-> !data_line)
		else $error("data pin high while nobody drives it");
	chk_clk_low_phase: assert property (@(posedge core_clk) disable iff (!rst_b)
		$fell(button_c) |-> !button_c [*4])
		else $error("clock low phase too short");
	chk_clk_high_phase: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(button_c) |-> button_c [*4])
		else $error("clock high phase too short");
endmodule

// ==== tb/tb_top.sv ====
// bench: function codes, shift level handling, programming and readback
`timescale 1ns/10ps
module tb_top;
	localparam int HOLD = 300;
	logic         core_clk = 1'b0;
	logic         rst_b = 1'b0;
	logic         btn_a = 1'b0;
	logic         btn_b = 1'b0;
	logic         shift = 1'b0;
	logic         tx_done = 1'b0;
	logic         start = 1'b0;
	logic [3:0]   rd_addr = 4'h0;
	logic [191:0] image = '0;
	logic [15:0]  rd_data;
	logic [3:0]   func_code;
	logic [1:0]   level;
	logic         tx_req;
	logic         done;
	logic         mism;
	int           error_cnt = 0;
	int           tests_run = 0;

	always #20 core_clk = ~core_clk;

	sbp_link_if i_sbp_link_if ();
	sbp_encoder_front #(.SETUP_MIN_CYC(40), .SETUP_MAX_CYC(60),
		.ERASE_CYC(30), .WRITE_CYC(20),
		.SHIFT_HOLD_CYC(HOLD)) i_sbp_encoder_front (
		.core_clk(core_clk), .rst_b(rst_b), .link(i_sbp_link_if),
		.button_a_input(btn_a), .button_b_input(btn_b),
		.shift_button(shift), .tx_done(tx_done), .nvm_rd_addr(rd_addr),
		.nvm_rd_data(rd_data), .tx_req(tx_req), .func_code(func_code),
		.sync_tx_req(), .shift_level(level), .prog_active(),
		.verify_active());
	// eight-cycle phases leave room for both synchronisers on readback
	sbp_programmer #(.SETUP_CYC(50), .HOLD_CYC(40), .ERASE_CYC(40),
		.WRITE_CYC(30), .PHASE_CYC(8)) i_sbp_programmer (
		.core_clk(core_clk), .rst_b(rst_b), .link(i_sbp_link_if),
		.start(start), .image(image), .busy(), .done(done),
		.mismatch(mism));
	// the checker's default windows match the timings set above
	sbp_link_assertions i_sbp_link_assertions (
		.core_clk(core_clk), .rst_b(rst_b),
		.button_c(i_sbp_link_if.button_c),
		.data_dev_out(i_sbp_link_if.data_dev_out),
		.data_dev_oe(i_sbp_link_if.data_dev_oe),
		.data_prg_out(i_sbp_link_if.data_prg_out),
		.data_prg_oe(i_sbp_link_if.data_prg_oe),
		.data_line(i_sbp_link_if.data_line));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic press_shift(input int n);
		repeat (n) begin
			shift = 1'b1;
			tick(4);
			shift = 1'b0;
			tick(4);
		end
	endtask
	task automatic t_codes;
		for (int l = 0; l < 4; l++) begin
			for (int b = 1; b < 4; b++) begin
				press_shift(l);
				check(16'(level), 16'(l));
				check(16'(tx_req), 16'h0000);
				{btn_b, btn_a} = 2'(b);
				for (int i = 0; i < 200 && tx_req !== 1'b1; i++)
					tick(1);
				check(16'(func_code), 16'(l * 4 + b - 1));
				{btn_b, btn_a} = 2'h0;
				tx_done = 1'b1;
				tick(1);
				tx_done = 1'b0;
				tick(4);
				check(16'(level), 16'h0000);
			end
		end
	endtask
	task automatic t_wrap_hold;
		press_shift(4);
		check(16'(level), 16'h0000);
		press_shift(2);
		tick(HOLD - 40);
		check(16'(tx_req), 16'h0000);
		check(16'(level), 16'h0002);
		tick(80);
		check(16'(level), 16'h0000);
	endtask
	task automatic t_prog;
		for (int k = 0; k < 12; k++)
			image[16 * k +: 16] = 16'h1230 + 16'(k);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		// raising the clock pin alone at level zero is a plain button C press
		for (int i = 0; i < 100 && tx_req !== 1'b1; i++)
			tick(1);
		check(16'(func_code), 16'h0003);
		// load plus readout takes a few thousand cycles at these settings
		for (int i = 0; i < 20000 && done !== 1'b1; i++)
			tick(1);
		check(16'(done), 16'h0001);
		check(16'(mism), 16'h0000);
		for (int k = 0; k < 12; k++) begin
			rd_addr = 4'(k);
			tick(2);
			check(rd_data, image[16 * k +: 16]);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#(40 * 40000);
		error_cnt++;
		summarize();
	end
	initial begin
		tick(20);
		rst_b = 1'b1;
		tick(4);
		t_codes();
		t_wrap_hold();
		t_prog();
		summarize();
	end
endmodule
